// ===== core/lht_lin_header.sv
// Contract
// - Master header opens with 13 dominant bit times, then 1 recessive bit time.
// - After the break the master sends the synch character 0x55.
// - Transmitted identifier is the value last written to the identifier register.
// - Transmit may compute and insert identifier parity bits automatically.
// - Transmit-ready flag rises when the identifier enters the transmit shift register.
// - Identifier-done flag sets once the transmitted identifier field is complete.
// - Break-done and identifier-done stay set until the status-reset command; the code also clears them on a write of one to the status register.
// - Slave frame handling starts only with a received header.
// - Slave detects break after 11 consecutive dominant bit times, checked continuously.
// - Before a break is detected the slave stays idle, ignoring characters.
// - On break the slave sets break-done, then uses the synch character for baud.
// - A received synch character other than 0x55 raises an inconsistent-synch error.
// - The character after the synch character is taken as the identifier.
// - On identifier reception set identifier-done and load the identifier character field.
// - Reception may compute and check the identifier parity bits automatically.
// - Header not complete within the maximum header time sets header time-out.
// - Status-reset command clears identifier-done, break-done and header time-out.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`include "lht_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module lht_lin_header
   import lht_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic lin_rx_in,
   output logic lin_tx_out
);

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      return adr == ofs;
   endfunction

   function automatic logic [1:0] id_parity(input logic [5:0] id);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
   endfunction

   logic bus_req;
   logic wr_lo;
   logic [1:0] mode_reg;
   lht_status_type mask_reg;
   lht_status_type status_reg;
   lht_status_type status_next;
   lht_status_type status_ev;
   lht_status_type status_clr;
   logic [7:0] lin_identifier_reg;
   logic [DIV_W-1:0] div_reg;
   logic status_reset_cmd;
   logic send_cmd;
   logic master;

   lht_tx_state_type tx_state;
   logic [DIV_W-1:0] tx_clk;
   logic [3:0] tx_bits;
   logic [9:0] tx_shift;
   logic tx_is_id;
   logic tx_tick;
   logic tx_holding_free_flag;
   logic tx_brk_ev;
   logic tx_id_ev;
   logic [7:0] tx_id_char;

   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   logic rx_fall;
   logic [19:0] low_cnt;
   logic [19:0] brk_thresh;
   logic brk_seen;
   logic brk_det;
   lht_rx_state_type rx_state;
   logic [DIV_W-1:0] rx_clk;
   logic [2:0] rx_n;
   logic [7:0] rx_shift;
   logic [7:0] rx_char;
   logic rx_phase_id;
   logic rx_id_ev;
   logic rx_sync_err_ev;
   logic rx_par_err_ev;
   logic baud_load;
   logic [19:0] meas_clk;
   logic [1:0] fall_n;
   logic [DIV_W-1:0] meas_div;

   logic hto_run;
   logic [DIV_W-1:0] hto_clk;
   logic [7:0] hto_bits;
   logic hto_ev;
   logic busy;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lo = bus_req & wb_we_i & wb_sel_i[0];
   assign master = mode_reg[`LHT_MODE_MASTER_BIT];
   assign status_reset_cmd = wr_lo & hit(wb_adr_i, `LHT_CTRL_OFS) & wb_dat_i[`LHT_CTRL_STATUS_RESET_CMD_BIT];
   assign send_cmd = wr_lo & hit(wb_adr_i, `LHT_CTRL_OFS) & wb_dat_i[`LHT_CTRL_SEND_BIT] & master
      & (tx_state == TX_IDLE);
   assign busy = (tx_state != TX_IDLE) | (rx_state != RX_IDLE) | hto_run;

   // The bus answers every request one cycle later, unmapped offsets read as zero.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            if (hit(wb_adr_i, `LHT_MODE_OFS)) begin
               wb_dat_o <= {30'h00000000, mode_reg};
            end else if (hit(wb_adr_i, `LHT_STAT_OFS)) begin
               wb_dat_o <= {25'h0000000, busy, tx_holding_free_flag, status_reg};
            end else if (hit(wb_adr_i, `LHT_MASK_OFS)) begin
               wb_dat_o <= {27'h0000000, mask_reg};
            end else if (hit(wb_adr_i, `LHT_ID_OFS)) begin
               wb_dat_o <= {24'h000000, lin_identifier_reg};
            end else if (hit(wb_adr_i, `LHT_DIV_OFS)) begin
               wb_dat_o <= {{(32 - DIV_W){1'b0}}, div_reg};
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_reg <= `LHT_MODE_RESET;
         mask_reg <= `LHT_MASK_RESET;
      end else if (wr_lo) begin
         if (hit(wb_adr_i, `LHT_MODE_OFS)) begin
            mode_reg <= wb_dat_i[1:0];
         end
         if (hit(wb_adr_i, `LHT_MASK_OFS)) begin
            mask_reg <= wb_dat_i[4:0];
         end
      end
   end

   // A received identifier overrides a software write in the same cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lin_identifier_reg <= `LHT_ID_RESET;
      end else if (rx_id_ev) begin
         lin_identifier_reg <= rx_char;
      end else if (wr_lo & hit(wb_adr_i, `LHT_ID_OFS)) begin
         lin_identifier_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_reg <= DIV_W'(`LHT_DIV_RESET);
      end else if (baud_load) begin
         div_reg <= meas_div;
      end else if (bus_req & wb_we_i & hit(wb_adr_i, `LHT_DIV_OFS) & (&wb_sel_i[1:0])) begin
         div_reg <= wb_dat_i[DIV_W-1:0];
      end
   end

   // Sticky flags: a set in the same cycle as a clear wins.
   always_comb begin
      status_ev = '0;
      status_ev.break_done = tx_brk_ev | brk_det;
      status_ev.identifier_done = tx_id_ev | rx_id_ev;
      status_ev.header_timeout = hto_ev;
      status_ev.sync_err = rx_sync_err_ev;
      status_ev.parity_err = rx_par_err_ev;
      status_clr = '0;
      if (wr_lo & hit(wb_adr_i, `LHT_STAT_OFS)) begin
         status_clr = wb_dat_i[4:0];
      end
      if (status_reset_cmd) begin
         status_clr = status_clr | `LHT_STATUS_RESET_CMD_CLEAR;
      end
      status_next = (status_reg & ~status_clr) | status_ev;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_reg <= '0;
         irq_o <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_o <= |(status_next & mask_reg);
      end
   end

   assign tx_id_char = mode_reg[`LHT_MODE_PARITY_BIT] ?
      {id_parity(lin_identifier_reg[5:0]), lin_identifier_reg[5:0]} : lin_identifier_reg;
   assign tx_tick = (tx_state != TX_IDLE) & (tx_clk == div_reg - 1'b1);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_clk <= '0;
      end else if (send_cmd | tx_tick) begin
         tx_clk <= '0;
      end else if (tx_state != TX_IDLE) begin
         tx_clk <= tx_clk + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_bits <= 4'h0;
         tx_shift <= 10'h3ff;
         tx_is_id <= 1'b0;
         tx_holding_free_flag <= 1'b1;
         tx_brk_ev <= 1'b0;
         tx_id_ev <= 1'b0;
         lin_tx_out <= 1'b1;
      end else begin
         tx_brk_ev <= 1'b0;
         tx_id_ev <= 1'b0;
         unique case (tx_state)
            TX_IDLE: begin
               lin_tx_out <= 1'b1;
               if (send_cmd) begin
                  tx_state <= TX_BREAK;
                  tx_bits <= `LHT_BREAK_TX_BITS;
                  tx_holding_free_flag <= 1'b0;
                  lin_tx_out <= 1'b0;
               end
            end
            TX_BREAK: begin
               if (tx_tick & (tx_bits == 4'h1)) begin
                  tx_state <= TX_DELIM;
                  tx_bits <= `LHT_DELIM_TX_BITS;
                  lin_tx_out <= 1'b1;
               end else if (tx_tick) begin
                  tx_bits <= tx_bits - 1'b1;
               end
            end
            TX_DELIM: begin
               if (tx_tick) begin
                  tx_brk_ev <= 1'b1;
                  tx_shift <= {1'b1, `LHT_SYNC_CHAR, 1'b0};
                  tx_bits <= `LHT_CHAR_BITS;
                  tx_is_id <= 1'b0;
                  tx_state <= TX_CHAR;
                  lin_tx_out <= 1'b0;
               end
            end
            TX_CHAR: begin
               if (tx_tick & (tx_bits == 4'h1)) begin
                  if (!tx_is_id) begin
                     tx_shift <= {1'b1, tx_id_char, 1'b0};
                     tx_bits <= `LHT_CHAR_BITS;
                     tx_is_id <= 1'b1;
                     tx_holding_free_flag <= 1'b1;
                     lin_tx_out <= 1'b0;
                  end else begin
                     tx_id_ev <= 1'b1;
                     tx_state <= TX_IDLE;
                     lin_tx_out <= 1'b1;
                  end
               end else if (tx_tick) begin
                  tx_bits <= tx_bits - 1'b1;
                  tx_shift <= {1'b1, tx_shift[9:1]};
                  lin_tx_out <= tx_shift[1];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= lin_rx_in;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   assign rx_fall = rx_prev & ~rx_sync;
   assign brk_thresh = 20'(div_reg) * `LHT_BREAK_RX_BITS;

   // Only one detection per dominant stretch, however long it lasts.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_cnt <= 20'h00000;
         brk_seen <= 1'b0;
         brk_det <= 1'b0;
      end else begin
         brk_det <= 1'b0;
         if (rx_sync | master) begin
            low_cnt <= 20'h00000;
            brk_seen <= 1'b0;
         end else if (!brk_seen) begin
            low_cnt <= low_cnt + 20'h00001;
            if (low_cnt == brk_thresh - 20'h00001) begin
               brk_det <= 1'b1;
               brk_seen <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_clk <= '0;
         rx_n <= 3'h0;
         rx_shift <= 8'h00;
         rx_char <= 8'h00;
         rx_phase_id <= 1'b0;
         rx_id_ev <= 1'b0;
         rx_sync_err_ev <= 1'b0;
         rx_par_err_ev <= 1'b0;
         baud_load <= 1'b0;
      end else begin
         rx_id_ev <= 1'b0;
         rx_sync_err_ev <= 1'b0;
         rx_par_err_ev <= 1'b0;
         baud_load <= 1'b0;
         rx_clk <= rx_clk + 1'b1;
         if (brk_det) begin
            rx_state <= RX_WAIT_HIGH;
            rx_phase_id <= 1'b0;
         end else begin
            unique case (rx_state)
               RX_IDLE: begin
               end
               RX_WAIT_HIGH: begin
                  if (rx_sync) begin
                     rx_state <= RX_WAIT_START;
                  end
               end
               RX_WAIT_START: begin
                  if (rx_fall) begin
                     rx_clk <= '0;
                     rx_state <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_clk == {1'b0, div_reg[DIV_W-1:1]}) begin
                     rx_clk <= '0;
                     rx_n <= 3'h0;
                     rx_state <= rx_sync ? RX_WAIT_START : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_clk == div_reg - 1'b1) begin
                     rx_clk <= '0;
                     rx_shift <= {rx_sync, rx_shift[7:1]};
                     rx_n <= rx_n + 1'b1;
                     if (rx_n == 3'h7) begin
                        rx_state <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rx_clk == div_reg - 1'b1) begin
                     rx_char <= rx_shift;
                     if (!rx_phase_id) begin
                        rx_sync_err_ev <= (rx_shift != `LHT_SYNC_CHAR);
                        baud_load <= (rx_shift == `LHT_SYNC_CHAR) & (meas_div != '0);
                        rx_phase_id <= 1'b1;
                        rx_state <= RX_WAIT_START;
                     end else begin
                        rx_id_ev <= 1'b1;
                        rx_par_err_ev <= mode_reg[`LHT_MODE_PARITY_BIT]
                           & (rx_shift[7:6] != id_parity(rx_shift[5:0]));
                        rx_state <= RX_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // The synch character spans eight bit times from its start edge to its fourth later falling edge.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meas_clk <= 20'h00000;
         fall_n <= 2'h0;
         meas_div <= '0;
      end else if ((rx_state == RX_WAIT_START) & rx_fall & !rx_phase_id) begin
         meas_clk <= 20'h00000;
         fall_n <= 2'h0;
         meas_div <= '0;
      end else if (!rx_phase_id & (rx_state inside {RX_START, RX_DATA, RX_STOP})) begin
         meas_clk <= meas_clk + 20'h00001;
         if (rx_fall) begin
            fall_n <= fall_n + 2'h1;
            if (fall_n == `LHT_SYNC_FALLS) begin
               meas_div <= DIV_W'((meas_clk + 20'h00001) >> 3);
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hto_run <= 1'b0;
         hto_clk <= '0;
         hto_bits <= 8'h00;
         hto_ev <= 1'b0;
      end else begin
         hto_ev <= 1'b0;
         if (brk_det) begin
            hto_run <= 1'b1;
            hto_clk <= '0;
            hto_bits <= 8'h00;
         end else if (rx_id_ev) begin
            hto_run <= 1'b0;
         end else if (hto_run) begin
            if (hto_clk == div_reg - 1'b1) begin
               hto_clk <= '0;
               hto_bits <= hto_bits + 8'h01;
               if (hto_bits == `LHT_HDR_MAX_BITS - 8'h01) begin
                  hto_ev <= 1'b1;
                  hto_run <= 1'b0;
               end
            end else begin
               hto_clk <= hto_clk + 1'b1;
            end
         end
      end
   end

endmodule // lht_lin_header

`default_nettype wire

// ===== shared/lht_regs.svh
`ifndef LHT_REGS_SVH
`define LHT_REGS_SVH

`define LHT_CTRL_OFS 8'h00
`define LHT_MODE_OFS 8'h04
`define LHT_STAT_OFS 8'h08
`define LHT_MASK_OFS 8'h0c
`define LHT_ID_OFS 8'h10
`define LHT_DIV_OFS 8'h14

`define LHT_CTRL_STATUS_RESET_CMD_BIT 0
`define LHT_CTRL_SEND_BIT 1
`define LHT_MODE_MASTER_BIT 0
`define LHT_MODE_PARITY_BIT 1
`define LHT_STAT_TXFREE_BIT 5
`define LHT_STAT_BUSY_BIT 6
`define LHT_STATUS_RESET_CMD_CLEAR 5'h07

`define LHT_MODE_RESET 2'h0
`define LHT_MASK_RESET 5'h00
`define LHT_ID_RESET 8'h00
`define LHT_DIV_RESET 16'h1458

`define LHT_BREAK_TX_BITS 4'hd
`define LHT_DELIM_TX_BITS 4'h1
`define LHT_CHAR_BITS 4'ha
`define LHT_BREAK_RX_BITS 20'h0000b
`define LHT_SYNC_CHAR 8'h55
`define LHT_SYNC_FALLS 2'h3
`define LHT_HDR_MAX_BITS 8'h31

`endif

// ===== shared/lht_pkg.sv
package lht_pkg;

   typedef struct packed {
      logic parity_err;
      logic sync_err;
      logic header_timeout;
      logic identifier_done;
      logic break_done;
   } lht_status_type;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_BREAK,
      TX_DELIM,
      TX_CHAR
   } lht_tx_state_type;

   typedef enum logic [2:0] {
      RX_IDLE,
      RX_WAIT_HIGH,
      RX_WAIT_START,
      RX_START,
      RX_DATA,
      RX_STOP
   } lht_rx_state_type;

endpackage

// ===== bench/lht_lin_properties.sv
`include "lht_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module lht_lin_checker
   import lht_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic lin_tx_out
);
   logic [DIV_W-1:0] div_reg;
   logic [19:0] low_cnt_reg, high_cnt_reg, brk_len, char_max, div_ext;
   logic [3:0] since_wr_reg;
   logic brk_seen_reg, sent_reg, taken_wr;
   assign taken_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign div_ext = 20'(div_reg);
   assign brk_len = div_ext * 20'hd;
   assign char_max = div_ext * 20'h9;

   // Slave sync may retune the divisor unseen here, so these figures hold for master traffic only.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_reg <= DIV_W'(`LHT_DIV_RESET);
      end else if (taken_wr && wb_adr_i == `LHT_DIV_OFS && wb_sel_i[1:0] == 2'h3) begin
         div_reg <= wb_dat_i[DIV_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_cnt_reg <= 20'h0;
         high_cnt_reg <= 20'h0;
         brk_seen_reg <= 1'b0;
      end else begin
         low_cnt_reg <= lin_tx_out ? 20'h0 : low_cnt_reg + 20'h1;
         high_cnt_reg <= lin_tx_out ? high_cnt_reg + 20'h1 : 20'h0;
         brk_seen_reg <= lin_tx_out ? (brk_seen_reg | (low_cnt_reg == brk_len)) : 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         since_wr_reg <= 4'hf;
         sent_reg <= 1'b0;
      end else begin
         since_wr_reg <= taken_wr ? 4'h0 : (since_wr_reg == 4'hf ? 4'hf : since_wr_reg + 4'h1);
         sent_reg <= sent_reg | (taken_wr && wb_adr_i == `LHT_CTRL_OFS && wb_dat_i[1]);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   read_zero_a: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == `LHT_CTRL_OFS || wb_adr_i > `LHT_DIV_OFS)
      |-> wb_dat_o == 32'h0) else $error("control or unmapped read not zero");
   tx_quiet_a: assert property (!sent_reg |-> lin_tx_out) else $error("transmit pin moved without send");
   break_len_a: assert property ($rose(lin_tx_out) && low_cnt_reg > char_max |-> low_cnt_reg == brk_len)
      else $error("break length wrong");
   low_max_a: assert property (low_cnt_reg <= brk_len) else $error("dominant run too long");
   delim_len_a: assert property ($fell(lin_tx_out) && brk_seen_reg |-> high_cnt_reg == div_ext)
      else $error("delimiter length wrong");
   irq_fall_a: assert property ($fell(irq_o) |-> since_wr_reg <= 4'h3)
      else $error("interrupt dropped without software write");

   cover property ($rose(lin_tx_out) && low_cnt_reg == brk_len);
   cover property ($rose(irq_o));
   cover property ($fell(irq_o));
   cover property (wb_ack_o && !wb_we_i);
endmodule // lht_lin_checker

bind lht_lin_header lht_lin_checker #(.DIV_W(DIV_W)) chk (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .lin_tx_out(lin_tx_out));
`default_nettype wire

// ===== bench/lht_lin_node.sv
`timescale 1ns/1ns
`default_nettype none

module lht_lin_node
   import lht_pkg::*;
#(
   parameter int BIT_CLKS = 10
) (
   input wire logic clk_sys,
   output logic bus_out
);
   // Between frames the pull-up leaves the bus recessive.
   initial bus_out = 1'b1;

   task automatic hold(input logic lvl, input int bits);
      @(posedge clk_sys);
      bus_out <= lvl;
      repeat (bits * BIT_CLKS - 1) @(posedge clk_sys);
   endtask

   task automatic send_break(input int bits);
      hold(1'b0, bits);
      hold(1'b1, 1);
   endtask

   task automatic send_char(input logic [7:0] c);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) hold(c[i], 1);
      hold(1'b1, 1);
   endtask
endmodule // lht_lin_node
`default_nettype wire

// ===== bench/lht_lin_header_bench.sv
`include "lht_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module lht_lin_header_bench
   import lht_pkg::*;
;
   localparam int DIV = 8;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, irq_o, lin_tx_out, node_tx;
   wire logic lin_bus;
   int err_total = 0, samples_checked = 0;
   logic [31:0] exp_q[$], msk_q[$];
   logic tx_q[$];
   logic [7:0] id_val, id_rx;
   logic [1:0] sel_lo = 2'h3;

   // The bus is wired-AND: either node pulls it dominant.
   assign lin_bus = node_tx & lin_tx_out;
   always #5 clk_sys = ~clk_sys;

   lht_lin_header #(.DIV_W(16)) uut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .lin_rx_in(lin_bus), .lin_tx_out(lin_tx_out));
   lht_lin_node #(.BIT_CLKS(20)) node (.clk_sys(clk_sys), .bus_out(node_tx));

   task automatic give_verdict;
      if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic compare_word(input logic [31:0] got, exp, msk);
      samples_checked++;
      if ((got & msk) !== (exp & msk)) begin
         err_total++;
         $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic compare_bit(input logic got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, exp, msk);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      // Upper lanes carry noise that no register may pick up.
      wb_dat_i <= {16'($urandom), dat[15:0]};
      wb_sel_i <= {2'($urandom), sel_lo};
      if (!we) begin
         exp_q.push_back(exp);
         msk_q.push_back(msk);
      end
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 40) begin
         err_total++;
         give_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(1'b1, adr, dat, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, msk);
      bus(1'b0, adr, 32'h0, exp, msk);
   endtask

   task automatic chk_irq(input logic exp);
      @(negedge clk_sys);
      compare_bit(irq_o, exp);
   endtask

   function automatic logic [7:0] par(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction

   function automatic void push_char(input logic [7:0] c);
      tx_q.push_back(1'b0);
      for (int i = 0; i < 8; i++) tx_q.push_back(c[i]);
      tx_q.push_back(1'b1);
   endfunction

   task automatic send_hdr(input logic [7:0] id);
      int n;
      n = 0;
      repeat (13) tx_q.push_back(1'b0);
      tx_q.push_back(1'b1);
      push_char(8'h55);
      push_char(id);
      wr(`LHT_CTRL_OFS, 32'h2);
      while (tx_q.size() > 0 && n < 1000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 1000) begin
         err_total++;
         give_verdict();
      end
      repeat (DIV + 3) @(posedge clk_sys);
   endtask

   always @(posedge clk_sys) begin
      if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) compare_word(wb_dat_o, exp_q.pop_front(), msk_q.pop_front());
   end

   // Samples every transmitted bit near its middle once a header starts.
   initial forever begin
      @(negedge lin_tx_out);
      repeat (DIV / 2) @(negedge clk_sys);
      while (tx_q.size() > 0) begin
         compare_bit(lin_tx_out, tx_q.pop_front());
         repeat (DIV) @(negedge clk_sys);
      end
   end

   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end

   initial begin
      void'($urandom(32'h5f4d));
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`LHT_CTRL_OFS, 32'h0, 32'hffffffff);
      rd(`LHT_MODE_OFS, 32'h0, 32'hffffffff);
      rd(`LHT_STAT_OFS, 32'h20, 32'hffffffff);
      rd(`LHT_MASK_OFS, 32'h0, 32'hffffffff);
      rd(`LHT_ID_OFS, 32'h0, 32'hffffffff);
      rd(`LHT_DIV_OFS, 32'h1458, 32'hffffffff);
      rd(8'hc7, 32'h0, 32'hffffffff);
      wr(`LHT_DIV_OFS, 32'(DIV));
      wr(`LHT_MODE_OFS, 32'h1);
      id_val = 8'($urandom);
      wr(`LHT_ID_OFS, {24'h0, id_val});
      sel_lo = 2'h0;
      wr(`LHT_ID_OFS, {24'h0, ~id_val});
      sel_lo = 2'h3;
      send_hdr(id_val);
      rd(`LHT_STAT_OFS, 32'h23, 32'h3f);
      chk_irq(1'b0);
      wr(`LHT_MASK_OFS, 32'h3);
      repeat (2) @(posedge clk_sys);
      chk_irq(1'b1);
      rd(`LHT_STAT_OFS, 32'h23, 32'h3f);
      wr(`LHT_CTRL_OFS, 32'h1);
      rd(`LHT_STAT_OFS, 32'h20, 32'h3f);
      chk_irq(1'b0);
      wr(`LHT_MODE_OFS, 32'h3);
      id_val = 8'($urandom);
      wr(`LHT_ID_OFS, {24'h0, id_val});
      send_hdr(par(id_val[5:0]));
      wr(`LHT_CTRL_OFS, 32'h1);
      // Slave side: the far node runs 20 clocks a bit, the divisor starts at 19.
      wr(`LHT_MODE_OFS, 32'h0);
      wr(`LHT_DIV_OFS, 32'h13);
      wr(`LHT_MASK_OFS, 32'h1f);
      node.send_break(10);
      node.send_char(8'h55);
      node.send_char(8'h3c);
      repeat (100) @(posedge clk_sys);
      rd(`LHT_STAT_OFS, 32'h20, 32'h3f);
      rd(`LHT_ID_OFS, {24'h0, id_val}, 32'hff);
      id_rx = 8'($urandom);
      node.send_break(13);
      node.send_char(8'h55);
      node.send_char(id_rx);
      repeat (600) @(posedge clk_sys);
      rd(`LHT_STAT_OFS, 32'h23, 32'h3f);
      rd(`LHT_ID_OFS, {24'h0, id_rx}, 32'hff);
      rd(`LHT_DIV_OFS, 32'h14, 32'hffff);
      chk_irq(1'b1);
      wr(`LHT_CTRL_OFS, 32'h1);
      chk_irq(1'b0);
      node.send_break(13);
      node.send_char(8'h54);
      node.send_char(8'h11);
      repeat (600) @(posedge clk_sys);
      rd(`LHT_STAT_OFS, 32'h08, 32'h08);
      wr(`LHT_STAT_OFS, 32'h1f);
      rd(`LHT_STAT_OFS, 32'h20, 32'h3f);
      node.send_break(13);
      repeat (1100) @(posedge clk_sys);
      rd(`LHT_STAT_OFS, 32'h25, 32'h3f);
      wr(`LHT_CTRL_OFS, 32'h1);
      rd(`LHT_STAT_OFS, 32'h20, 32'h3f);
      wr(`LHT_MODE_OFS, 32'h2);
      node.send_break(13);
      node.send_char(8'h55);
      node.send_char(par(6'h15) ^ 8'h80);
      repeat (600) @(posedge clk_sys);
      rd(`LHT_STAT_OFS, 32'h33, 32'h3f);
      give_verdict();
   end
endmodule // lht_lin_header_bench
`default_nettype wire
